// file: shared/prsp_pkg.sv
package prsp_pkg;

  // ------------------------------------------------------------
  // Widths and counts
  // ------------------------------------------------------------
  localparam int         WORD_BITS = 32;
  localparam int         NUM_CH    = 3;
  localparam logic [4:0] BIT_LAST  = 5'h1F;
  localparam logic [4:0] RIGHT_BASE = 5'h10;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PIN_SEL_OFF = 8'h26;
  localparam logic [7:0] CH3_OFF     = 8'h2A;
  localparam logic [7:0] CH4_OFF     = 8'h2B;
  localparam logic [7:0] CH5_OFF     = 8'h2C;
  localparam logic [7:0] CH6_OFF     = 8'h2D;
  localparam logic [7:0] STATUS_OFF  = 8'h30;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [7:0] CH3_RST     = 8'h02;
  localparam logic [7:0] CH4_RST     = 8'h03;
  localparam logic [7:0] CH5_RST     = 8'h04;
  localparam logic [7:0] CH6_RST     = 8'h05;
  localparam logic [2:0] PIN_SEL_RST = 3'h0;
  localparam logic [3:0][7:0] CFG_RST = {CH6_RST, CH5_RST, CH4_RST, CH3_RST};
  localparam int         EN_BIT      = 5;
  localparam int         SRC_LSB     = 5;
  localparam int         PIN_SEL_LSB = 2;
  localparam logic [7:0] MASK_ENA    = 8'h3F;
  localparam logic [7:0] MASK_SRC    = 8'h7F;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_OFF  = 2'b00,
    SRC_DAC  = 2'b01,
    SRC_LOOP = 2'b10,
    SRC_RSVD = 2'b11
  } prsp_src_type;

  typedef enum logic {
    LINK_HUNT = 1'b0,
    LINK_RUN  = 1'b1
  } prsp_link_type;

  typedef struct packed {
    logic [4:0]           code;
    logic [WORD_BITS-1:0] data;
  } prsp_word_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prsp_req_type;

endpackage

// file: src/prsp_sync3.sv
`timescale 1ns/1ps
module prsp_sync3 #(
  parameter int W = 4
) (
  // Clock and reset
  input  logic         ref_clk,
  input  logic         rstn,
  // Pins and filtered levels
  input  logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import prsp_pkg::*;

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // A change is taken only once the second and third stages agree.
  always_comb begin
    lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule

// file: src/prsp_slot_deser.sv
`timescale 1ns/1ps
module prsp_slot_deser (
  // Clock and reset
  input  logic                    ref_clk,
  input  logic                    rstn,
  // Frame timing
  input  logic                    bit_stb,
  input  logic                    frame_start,
  input  logic                    right_half,
  input  logic                    tdm_fmt,
  input  logic                    din,
  // Captured slot
  output prsp_pkg::prsp_word_type word,
  output logic                    word_vld,
  output prsp_pkg::prsp_link_type link_state
);
  import prsp_pkg::*;

  logic [4:0]           bit_q, bit_d, slot_q, slot_d;
  logic [3:0]           slot_lo;
  logic                 right_q, right_d, tdm_q, tdm_d, vld_q, vld_d;
  logic [WORD_BITS-1:0] sh_q, sh_d;
  prsp_word_type        word_q, word_d;
  prsp_link_type        link_q, link_d;

  assign slot_lo = slot_q[3:0];

  always_comb begin
    bit_d   = bit_q;
    slot_d  = slot_q;
    right_d = right_q;
    tdm_d   = tdm_q;
    sh_d    = sh_q;
    word_d  = word_q;
    vld_d   = 1'b0;
    link_d  = link_q;
    if (bit_stb) begin
      sh_d = {sh_q[WORD_BITS-2:0], din};
      if (frame_start) begin
        bit_d   = 5'h01;
        slot_d  = 5'h00;
        right_d = right_half;
        tdm_d   = tdm_fmt;
        link_d  = LINK_RUN;
      end else begin
        case (link_q)
          LINK_RUN: begin
            if (bit_q == BIT_LAST) begin
              word_d.data = sh_d;
              word_d.code = tdm_q ? slot_q :
                (right_q ? (RIGHT_BASE | {1'b0, slot_lo}) : {1'b0, slot_lo});
              vld_d  = 1'b1;
              bit_d  = 5'h00;
              slot_d = slot_q + 5'h01;
            end else begin
              bit_d = bit_q + 5'h01;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bit_q   <= 5'h00;
      slot_q  <= 5'h00;
      right_q <= 1'b0;
      tdm_q   <= 1'b0;
      sh_q    <= '0;
      word_q  <= '0;
      vld_q   <= 1'b0;
      link_q  <= LINK_HUNT;
    end else begin
      bit_q   <= bit_d;
      slot_q  <= slot_d;
      right_q <= right_d;
      tdm_q   <= tdm_d;
      sh_q    <= sh_d;
      word_q  <= word_d;
      vld_q   <= vld_d;
      link_q  <= link_d;
    end
  end

  assign word       = word_q;
  assign word_vld   = vld_q;
  assign link_state = link_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_left_slot;
    @(posedge ref_clk) disable iff (!rstn)
    vld_q && (!$past(right_q) || $past(tdm_q))
      |-> word_q.code == ($past(tdm_q) ? $past(slot_q) : {1'b0, $past(slot_lo)});
  endproperty
  a_left_slot: assert property (p_left_slot) else $error("left or TDM slot code wrong");

  property p_right_slot;
    @(posedge ref_clk) disable iff (!rstn)
    vld_q && $past(right_q) && !$past(tdm_q) |-> word_q.code == {1'b1, $past(slot_lo)};
  endproperty
  a_right_slot: assert property (p_right_slot) else $error("right slot code wrong");

endmodule

// file: src/prsp_rx_slot_map.sv
`timescale 1ns/1ps
// Behaviour
// - Channel 3 data goes to DAC channel 3 only while its enable bit is set.
// - Channel 4 data goes to DAC channel 4 only while its enable bit is set.
// - Channel 5 source code: 0 off, 1 DAC 5, 2 ADC 1 loopback, 3 reserved.
// - Slot codes 0-15 pick TDM slot or left half-frame slot of that number.
// - Slot codes 16-31 pick TDM slot or right half-frame slot code minus 16.
// - Channel 3 register at 0x2A resets to 0x02: disabled, slot 2.
// - Channel 4 register at 0x2B resets to 0x03: disabled, slot 3.
// - Channel 5 register at 0x2C resets to 0x04: disabled, slot 4.
// - Channel 6 register exists at 0x2D and resets to 0x05.
// - Channels 3 to 5 each read data pin A when their pin select bit is 0, else pin B.
module prsp_rx_slot_map (
  // Clock and reset
  input  logic                                   ref_clk,
  input  logic                                   rstn,
  // Register port
  input  prsp_pkg::prsp_req_type                 reg_req,
  output logic [7:0]                             reg_rdata,
  output logic                                   reg_rvalid,
  // Frame format
  input  logic                                   half_frame_fmt,
  // Serial link pins
  input  logic                                   bclk_pin,
  input  logic                                   fsync_pin,
  input  logic                                   serial_data_in_a,
  input  logic                                   serial_data_in_b,
  // DAC channels 3 to 5 and loopback
  output logic [prsp_pkg::NUM_CH-1:0][prsp_pkg::WORD_BITS-1:0] dac_data,
  output logic [prsp_pkg::NUM_CH-1:0]            dac_vld,
  output logic [prsp_pkg::WORD_BITS-1:0]         loop_data,
  output logic                                   loop_vld
);
  import prsp_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic slot_hit(input prsp_word_type w, input logic v,
                                    input logic [4:0] s);
    slot_hit = v && (w.code == s);
  endfunction

  // ------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------
  logic [3:0]    pins_lvl;
  logic          bclk_prev_q, bclk_prev_d, fs_prev_q, fs_prev_d;
  logic          bit_stb, frame_start;
  prsp_word_type word_a, word_b;
  logic          vld_a, vld_b;
  prsp_link_type link_a;

  prsp_sync3 #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pin     ({serial_data_in_b, serial_data_in_a, fsync_pin, bclk_pin}),
    .level   (pins_lvl)
  );

  // Bits are taken on the rising bit-clock edge; the 80 ns link period
  // leaves sixteen reference cycles, ample for the filter latency.
  assign bit_stb = pins_lvl[0] & ~bclk_prev_q;
  // TDM frames start on a sync rise; half-frame formats on either edge.
  assign frame_start = bit_stb & (half_frame_fmt ? (pins_lvl[1] ^ fs_prev_q)
                                                 : (pins_lvl[1] & ~fs_prev_q));

  always_comb begin
    bclk_prev_d = pins_lvl[0];
    fs_prev_d   = bit_stb ? pins_lvl[1] : fs_prev_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bclk_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
    end else begin
      bclk_prev_q <= bclk_prev_d;
      fs_prev_q   <= fs_prev_d;
    end
  end

  prsp_slot_deser u_deser_a (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .bit_stb     (bit_stb),
    .frame_start (frame_start),
    .right_half  (pins_lvl[1]),
    .tdm_fmt     (~half_frame_fmt),
    .din         (pins_lvl[2]),
    .word        (word_a),
    .word_vld    (vld_a),
    .link_state  (link_a)
  );

  prsp_slot_deser u_deser_b (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .bit_stb     (bit_stb),
    .frame_start (frame_start),
    .right_half  (pins_lvl[1]),
    .tdm_fmt     (~half_frame_fmt),
    .din         (pins_lvl[3]),
    .word        (word_b),
    .word_vld    (vld_b),
    .link_state  ()
  );

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [3:0][7:0] cfg_q, cfg_d;
  logic [2:0]      pin_sel_q, pin_sel_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            rvalid_q, rvalid_d;
  prsp_src_type    src5;

  always_comb begin
    cfg_d     = cfg_q;
    pin_sel_d = pin_sel_q;
    rdata_d   = rdata_q;
    rvalid_d  = reg_req.rd;
    if (reg_req.wr) begin
      case (reg_req.addr)
        CH3_OFF:     cfg_d[0]  = reg_req.wdata & MASK_ENA;
        CH4_OFF:     cfg_d[1]  = reg_req.wdata & MASK_ENA;
        CH5_OFF:     cfg_d[2]  = reg_req.wdata & MASK_SRC;
        CH6_OFF:     cfg_d[3]  = reg_req.wdata & MASK_SRC;
        PIN_SEL_OFF: pin_sel_d = reg_req.wdata[PIN_SEL_LSB +: 3];
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        CH3_OFF:     rdata_d = cfg_q[0];
        CH4_OFF:     rdata_d = cfg_q[1];
        CH5_OFF:     rdata_d = cfg_q[2];
        CH6_OFF:     rdata_d = cfg_q[3];
        PIN_SEL_OFF: rdata_d = {3'h0, pin_sel_q, 2'h0};
        STATUS_OFF:  rdata_d = {link_a == LINK_RUN, 2'h0, word_a.code};
        default:     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q     <= CFG_RST;
      pin_sel_q <= PIN_SEL_RST;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
    end else begin
      cfg_q     <= cfg_d;
      pin_sel_q <= pin_sel_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign src5       = prsp_src_type'(cfg_q[2][SRC_LSB +: 2]);

  // ------------------------------------------------------------
  // Slot matching
  // ------------------------------------------------------------
  prsp_word_type [NUM_CH-1:0] ch_word;
  logic [NUM_CH-1:0]          ch_vld, ch_hit;

  genvar g;
  for (g = 0; g < NUM_CH; g++) begin : g_ch
    assign ch_word[g] = pin_sel_q[g] ? word_b : word_a;
    assign ch_vld[g]  = pin_sel_q[g] ? vld_b : vld_a;
    assign ch_hit[g]  = slot_hit(ch_word[g], ch_vld[g], cfg_q[g][4:0]);
  end

  logic [NUM_CH-1:0][WORD_BITS-1:0] dac_q, dac_d;
  logic [NUM_CH-1:0]                dvld_q, dvld_d;
  logic [WORD_BITS-1:0]             loop_q, loop_d;
  logic                             lvld_q, lvld_d;

  always_comb begin
    dvld_d[0] = ch_hit[0] & cfg_q[0][EN_BIT];
    dvld_d[1] = ch_hit[1] & cfg_q[1][EN_BIT];
    dvld_d[2] = ch_hit[2] & (src5 == SRC_DAC);
    lvld_d    = ch_hit[2] & (src5 == SRC_LOOP);
    for (int i = 0; i < NUM_CH; i++) begin
      dac_d[i] = dvld_d[i] ? ch_word[i].data : dac_q[i];
    end
    loop_d = lvld_d ? ch_word[2].data : loop_q;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      dac_q  <= '0;
      dvld_q <= '0;
      loop_q <= '0;
      lvld_q <= 1'b0;
    end else begin
      dac_q  <= dac_d;
      dvld_q <= dvld_d;
      loop_q <= loop_d;
      lvld_q <= lvld_d;
    end
  end

  assign dac_data  = dac_q;
  assign dac_vld   = dvld_q;
  assign loop_data = loop_q;
  assign loop_vld  = lvld_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ch3_route;
    @(posedge ref_clk) disable iff (!rstn)
    dvld_q[0] |-> $past(cfg_q[0][EN_BIT]) && dac_q[0] == $past(ch_word[0].data);
  endproperty
  a_ch3_route: assert property (p_ch3_route) else $error("channel 3 routed wrongly");

  property p_ch4_route;
    @(posedge ref_clk) disable iff (!rstn)
    $past(ch_hit[1]) && $past(cfg_q[1][EN_BIT]) |-> dvld_q[1];
  endproperty
  a_ch4_route: assert property (p_ch4_route) else $error("channel 4 word lost");

  property p_ch5_src;
    @(posedge ref_clk) disable iff (!rstn)
    (lvld_q |-> $past(src5) == SRC_LOOP) and (dvld_q[2] |-> $past(src5) == SRC_DAC);
  endproperty
  a_ch5_src: assert property (p_ch5_src) else $error("channel 5 source wrong");

  property p_ch3_rst;
    @(posedge ref_clk) disable iff (!rstn)
    !$past(rstn) |-> cfg_q[0] == CH3_RST;
  endproperty
  a_ch3_rst: assert property (p_ch3_rst) else $error("channel 3 reset value wrong");

  property p_ch4_rst;
    @(posedge ref_clk) disable iff (!rstn)
    !$past(rstn) |-> cfg_q[1] == CH4_RST;
  endproperty
  a_ch4_rst: assert property (p_ch4_rst) else $error("channel 4 reset value wrong");

  property p_ch5_rst;
    @(posedge ref_clk) disable iff (!rstn)
    !$past(rstn) |-> cfg_q[2] == CH5_RST && !lvld_q && !dvld_q[2];
  endproperty
  a_ch5_rst: assert property (p_ch5_rst) else $error("channel 5 reset value wrong");

  property p_ch6_rd;
    @(posedge ref_clk) disable iff (!rstn)
    reg_req.rd && !reg_req.wr && reg_req.addr == CH6_OFF && !$past(reg_req.wr)
      |=> reg_rvalid && reg_rdata == $past(cfg_q[3]);
  endproperty
  a_ch6_rd: assert property (p_ch6_rd) else $error("channel 6 register read wrong");

  property p_pin_sel;
    @(posedge ref_clk) disable iff (!rstn)
    dvld_q[0] |-> $past(pin_sel_q[0] ? vld_b : vld_a);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("channel 3 from wrong pin");

  property p_discard;
    @(posedge ref_clk) disable iff (!rstn)
    !cfg_q[1][EN_BIT] ##1 !$past(cfg_q[1][EN_BIT]) |-> !dvld_q[1] && $stable(dac_q[1]);
  endproperty
  a_discard: assert property (p_discard) else $error("disabled channel 4 updated");

  property p_ch6_rst;
    @(posedge ref_clk) disable iff (!rstn)
    !$past(rstn) |-> cfg_q[3] == CH6_RST;
  endproperty
  a_ch6_rst: assert property (p_ch6_rst) else $error("channel 6 reset value wrong");

  property p_loop_off;
    @(posedge ref_clk) disable iff (!rstn)
    $past(src5 != SRC_LOOP) |-> !lvld_q && $stable(loop_data);
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("loopback updated while off");

  c_ch3_word: cover property (@(posedge ref_clk) disable iff (!rstn) dvld_q[0]);
  c_loop: cover property (@(posedge ref_clk) disable iff (!rstn) lvld_q);
  c_ch5_dac: cover property (@(posedge ref_clk) disable iff (!rstn) dvld_q[2]);
  c_half_fmt: cover property (@(posedge ref_clk) disable iff (!rstn)
    half_frame_fmt && dvld_q[1]);

endmodule

// file: tb/prsp_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host serial source
// ------------------------------------------------------------
// The bit clock is gated and only runs inside frames, as a real host may do.
module prsp_host_model (
  // Serial link
  output logic bclk_pin,
  output logic fsync_pin,
  output logic sd_a,
  output logic sd_b
);
  logic [31:0] wa [32];
  logic [31:0] wb [32];

  initial begin
    bclk_pin  = 1'b0;
    fsync_pin = 1'b0;
    sd_a      = 1'b0;
    sd_b      = 1'b0;
  end

  // Data and sync change while the bit clock is low and are sampled on its rise.
  task automatic send_bit(input logic fs, input logic a, input logic b);
    fsync_pin = fs;
    sd_a = a;
    sd_b = b;
    #40;
    bclk_pin = 1'b1;
    #40;
    bclk_pin = 1'b0;
  endtask

  // A lead-in bit at the opposite sync level makes the frame's first edge visible.
  task automatic send_frame(input logic half, input int n);
    // Step off the reference clock edge so the pin filter never races the host.
    #1;
    send_bit(half, ~sd_a, ~sd_b);
    for (int h = 0; h < (half ? 2 : 1); h++) begin
      for (int s = 0; s < n; s++) begin
        for (int b = 31; b >= 0; b--) begin
          send_bit(half ? h[0] : (s == 0 && b == 31), wa[h*16+s][b], wb[h*16+s][b]);
        end
      end
    end
    // Released data lines toggle so a stale bit is never mistaken for data.
    sd_a = ~sd_a;
    sd_b = ~sd_b;
  endtask
endmodule

// file: tb/tb_prsp_rx_slot_map.sv
`timescale 1ns/1ps
module tb_prsp_rx_slot_map;
  import prsp_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                             ref_clk;
  logic                             rstn;
  prsp_req_type                     reg_req;
  logic [7:0]                       reg_rdata;
  logic                             reg_rvalid;
  logic                             half_frame_fmt;
  logic                             bclk_pin;
  logic                             fsync_pin;
  logic                             sd_a;
  logic                             sd_b;
  logic [NUM_CH-1:0][WORD_BITS-1:0] dac_data;
  logic [NUM_CH-1:0]                dac_vld;
  logic [WORD_BITS-1:0]             loop_data;
  logic                             loop_vld;
  int                               mismatches;
  int                               n_compared;
  int                               seed;
  logic [31:0]                      got [4][$];

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  prsp_rx_slot_map DUT (
    .ref_clk          (ref_clk),
    .rstn             (rstn),
    .reg_req          (reg_req),
    .reg_rdata        (reg_rdata),
    .reg_rvalid       (reg_rvalid),
    .half_frame_fmt   (half_frame_fmt),
    .bclk_pin         (bclk_pin),
    .fsync_pin        (fsync_pin),
    .serial_data_in_a (sd_a),
    .serial_data_in_b (sd_b),
    .dac_data         (dac_data),
    .dac_vld          (dac_vld),
    .loop_data        (loop_data),
    .loop_vld         (loop_vld)
  );

  prsp_host_model host (
    .bclk_pin  (bclk_pin),
    .fsync_pin (fsync_pin),
    .sd_a      (sd_a),
    .sd_b      (sd_b)
  );

  // ------------------------------------------------------------
  // Output collection
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (dac_vld[i] === 1'b1) got[i].push_back(dac_data[i]);
    end
    if (loop_vld === 1'b1) got[3].push_back(loop_data);
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge ref_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    reg_req <= '0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (reg_rvalid !== 1'b1 && n < 4);
    check("reg_rvalid", {31'h0, reg_rvalid}, 32'h1);
    check($sformatf("reg %h", a), {24'h0, reg_rdata}, {24'h0, exp});
  endtask

  task automatic reset_values();
    check_reg(8'h2A, 8'h02);
    check_reg(8'h2B, 8'h03);
    check_reg(8'h2C, 8'h04);
    check_reg(8'h2D, 8'h05);
    check_reg(PIN_SEL_OFF, 8'h00);
    check_reg(8'h40, 8'h00);
    check_reg(STATUS_OFF, 8'h00);
    $display("test reset_values done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] w;
    logic [4:0]  code [3];
    logic [7:0]  cfg [3];
    logic [2:0]  en;
    logic [2:0]  pin;
    logic [1:0]  src;
    logic        half;
    logic        act;
    logic        present;
    int          n;
    int          k;
    string       nm [4];
    nm = '{"ch3", "ch4", "ch5", "loop"};
    seed = 32'h5A2CBC4B;
    mismatches = 0;
    n_compared = 0;
    rstn = 1'b0;
    reg_req = '0;
    half_frame_fmt = 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    reset_values();
    // Reserved bits written as one must not stick.
    reg_write(8'h2A, 8'hFF);
    check_reg(8'h2A, 8'h3F);
    reg_write(8'h2C, 8'hFF);
    check_reg(8'h2C, 8'h7F);
    reg_write(8'h2D, 8'hFF);
    check_reg(8'h2D, 8'h7F);
    reg_write(8'h40, 8'hFF);
    check_reg(8'h40, 8'h00);
    $display("test reserved_bits done");
    // The last frame is a long TDM frame so slot codes 16 and up are real slots.
    for (int f = 0; f < 13; f++) begin
      half = (f == 12) ? 1'b0 : f[0];
      n = (f == 12) ? 20 : 3;
      src = f[2:1];
      for (int c = 0; c < 3; c++) begin
        r = $random(seed);
        code[c] = {r[4], 2'b00, r[1:0]};
        en[c] = r[5] | r[6];
        pin[c] = r[7];
        cfg[c] = (c == 2) ? {1'b0, src, code[2]} : {2'b00, en[c], code[c]};
        reg_write(8'(8'h2A + c), cfg[c]);
        check_reg(8'(8'h2A + c), cfg[c]);
      end
      reg_write(PIN_SEL_OFF, {3'b000, pin, 2'b00});
      check_reg(PIN_SEL_OFF, {3'b000, pin, 2'b00});
      for (int s = 0; s < 32; s++) begin
        host.wa[s] = $random(seed);
        host.wb[s] = $random(seed);
      end
      @(posedge ref_clk);
      half_frame_fmt <= half;
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) got[i].delete();
      host.send_frame(half, n);
      repeat (40) @(posedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        k = (c == 3) ? 2 : c;
        act = (c < 2) ? en[c] : (c == 2) ? (src == 2'd1) : (src == 2'd2);
        present = half ? (code[k][3:0] < n) : (code[k] < n);
        w = pin[k] ? host.wb[code[k]] : host.wa[code[k]];
        check({nm[c], " count"}, 32'(got[c].size()), {31'h0, act & present});
        if (act && present && got[c].size() > 0) begin
          check({nm[c], " word"}, got[c][0], w);
        end
      end
      check_reg(STATUS_OFF, 8'(8'h7F + n + (half ? 16 : 0)));
      $display("test frame %0d done", f);
    end
    do_reset();
    reset_values();
    tally_and_finish();
  end

  // A hung handshake or frame ends the run as a failure.
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
